// file: wake_irq_phy_access_regs_bench.sv
// Self-checking bench for the wake, early receive and PHY access register slice.
// Assumes a 10 MHz clock and the PHY model on the management pins.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module wake_irq_phy_access_regs_bench;
   import wipa_pkg::*;
   localparam logic [ADDR_W-1:0] A_WCFG = {IDX_WAKE_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] A_THR  = {IDX_ERX_THR, 2'b00};
   localparam logic [ADDR_W-1:0] A_PHY  = {IDX_PHY_ACC, 2'b00};
   localparam logic [ADDR_W-1:0] A_WCTL = {IDX_WAKE_CTRL, 2'b00};
   logic              clk, rst, reg_we, reg_re, host_bus_reset, eeprom_load, wake_frame_hit;
   logic              wake_frame_bcast, wake_frame_mcast, wake_frame_ucast, power_event_req;
   logic              isolation_in_n, power_event_out_n, lan_wake_pin, rx_pkt_start, early_rx_irq;
   logic              mdc, mdio_o, mdio_oe, phy_drv, mdio_wire;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0]       reg_wdata, reg_rdata, rv;
   logic [1:0]        eeprom_wake_bits;
   logic [3:0]        rx_dma_bytes;
   int                failures = 0;
   int                samples_checked = 0;
   int                irq_n = 0;

   assign mdio_wire = mdio_oe ? mdio_o : phy_drv;

   wipa_reg_bank u_wipa_reg_bank (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .host_bus_reset(host_bus_reset), .eeprom_load(eeprom_load),
      .eeprom_wake_bits(eeprom_wake_bits), .wake_frame_hit(wake_frame_hit), .wake_frame_bcast(wake_frame_bcast),
      .wake_frame_mcast(wake_frame_mcast), .wake_frame_ucast(wake_frame_ucast),
      .power_event_req(power_event_req), .isolation_in_n(isolation_in_n),
      .power_event_out_n(power_event_out_n), .lan_wake_pin(lan_wake_pin), .rx_pkt_start(rx_pkt_start),
      .rx_dma_bytes(rx_dma_bytes), .early_rx_irq(early_rx_irq), .mdc(mdc), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .mdio_i(mdio_wire)
   );
   wipa_phy_model u_wipa_phy_model (.mdc(mdc), .md_line(mdio_wire), .md_drv(phy_drv));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) if (early_rx_irq === 1'b1) irq_n <= irq_n + 1;

   task automatic stop_test;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd

   task automatic frame(input int k);
      @(posedge clk);
      wake_frame_hit <= 1'b1;
      {wake_frame_bcast, wake_frame_mcast, wake_frame_ucast} <= 3'(1 << k);
      @(posedge clk);
      wake_frame_hit <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : frame

   task automatic pkt(input int n);
      @(posedge clk);
      rx_pkt_start <= 1'b1;
      @(posedge clk);
      rx_pkt_start <= 1'b0;
      rx_dma_bytes <= 4'h4;
      repeat (n) @(posedge clk);
      rx_dma_bytes <= 4'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask : pkt

   task automatic phy_wait(input logic want);
      int t = 0;
      do begin
         rd(A_PHY);
         t++;
      end while (rv[31] !== want && t < 200);
      `CHK(rv[31], want)
   endtask : phy_wait

   initial begin
      #(100 * 6000);
      failures++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      {reg_we, reg_re, host_bus_reset, eeprom_load, wake_frame_hit, power_event_req, rx_pkt_start} = 7'h00;
      {wake_frame_bcast, wake_frame_mcast, wake_frame_ucast} = 3'h0;
      isolation_in_n = 1'b1;
      reg_addr = '0;
      reg_wdata = 32'h0000_0000;
      eeprom_wake_bits = 2'h0;
      rx_dma_bytes = 4'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(A_WCFG); `CHK(rv, 32'h0000_0000)
      rd(A_THR); `CHK(rv, 32'h0000_0000)
      `CHK(power_event_out_n, 1'b1)
      `CHK(lan_wake_pin, 1'b0)
      wr(10'h3fc, 32'hffff_ffff); rd(10'h3fc); `CHK(rv, 32'h0000_0000)
      wr(A_WCFG, 32'hffff_ffff); rd(A_WCFG); `CHK(rv, 32'h0000_0073)
      wr(A_WCFG, 32'h0000_0000);
      @(posedge clk);
      eeprom_load <= 1'b1;
      eeprom_wake_bits <= 2'h2;
      @(posedge clk);
      eeprom_load <= 1'b0;
      rd(A_WCFG); `CHK(rv, 32'h0000_0002)
      for (int k = 0; k < 3; k++) begin
         wr(A_WCFG, 32'(1 << (4 + (k + 1) % 3))); frame(k); `CHK(power_event_out_n, 1'b1)
         wr(A_WCFG, 32'(1 << (4 + k))); frame(k); `CHK(power_event_out_n, 1'b0)
         wr(A_WCTL, 32'h0000_0002); `CHK(power_event_out_n, 1'b1)
      end
      wr(A_WCFG, 32'h0000_0002);
      @(posedge clk);
      power_event_req <= 1'b1;
      @(posedge clk);
      power_event_req <= 1'b0;
      #1 `CHK(lan_wake_pin, 1'b1)
      wr(A_WCTL, 32'h0000_0001); `CHK(lan_wake_pin, 1'b0)
      @(posedge clk);
      isolation_in_n <= 1'b0;
      #1 `CHK(lan_wake_pin, 1'b1)
      rd(A_WCTL); `CHK(rv, 32'h0000_0003)
      wr(A_WCFG, 32'h0000_0000); `CHK(lan_wake_pin, 1'b0)
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         host_bus_reset <= 1'b1;
         @(posedge clk);
         host_bus_reset <= 1'b0;
         #1 `CHK(power_event_out_n, 1'(m))
         wr(A_WCFG, 32'h0000_0001);
      end
      @(posedge clk);
      isolation_in_n <= 1'b1;
      wr(A_WCTL, 32'h0000_0000);
      wr(A_THR, 32'hffff_fffc); rd(A_THR); `CHK(rv, 32'h0000_0ffc)
      wr(A_THR, 32'h0000_0010);
      wr(A_WCTL, 32'h0000_0008);
      pkt(3); `CHK(irq_n, 0)
      pkt(4); `CHK(irq_n, 1)
      pkt(8); `CHK(irq_n, 1)
      wr(A_WCTL, 32'h0000_000c);
      pkt(4);
      pkt(4); `CHK(irq_n, 3)
      rd(A_WCTL); `CHK(rv, 32'h0000_001c)
      wr(A_THR, 32'h0000_0000);
      pkt(8); `CHK(irq_n, 3)
      wr(A_PHY, {1'b1, 10'h000, 5'h03, 16'h1234});
      wr(A_PHY, {1'b1, 10'h000, 5'h03, 16'hbeef});
      phy_wait(1'b0);
      `CHK(u_wipa_phy_model.mem[3], 16'h1234)
      wr(A_PHY, {1'b0, 10'h000, 5'h09, 16'h0000});
      phy_wait(1'b1);
      `CHK(rv[15:0], 16'h5a09)
      stop_test();
   end
endmodule : wake_irq_phy_access_regs_bench

// file: wipa_core_if.sv
// Carrier between the register bank and its management and early receive engines.
// Assumes all parties run on the one register clock.
`timescale 1ns/100ps
interface wipa_core_if;
   import wipa_pkg::*;
   logic              md_start;
   logic              md_write;
   logic [REG_W-1:0]  md_reg;
   logic [DATA_W-1:0] md_wdata;
   logic              md_done;
   logic [DATA_W-1:0] md_rdata;
   logic [THR_W-1:0]  erx_thr;
   logic              erx_multi;
   logic              erx_mode;
   logic              erx_rearm;
   logic              erx_irq;

   modport bank (output md_start, md_write, md_reg, md_wdata, erx_thr, erx_multi, erx_mode, erx_rearm,
                 input md_done, md_rdata, erx_irq);
   modport mdio (input md_start, md_write, md_reg, md_wdata, output md_done, md_rdata);
   modport erx  (input erx_thr, erx_multi, erx_mode, erx_rearm, output erx_irq);
endinterface : wipa_core_if

// file: wipa_erx_eng.sv
// Early receive byte counter; raises one pulse when a packet crosses the threshold.
// Assumes rx_pkt_start precedes the byte counts of each packet.
`timescale 1ns/100ps
module wipa_erx_eng (
   input  wire logic       clk,
   input  wire logic       rst,
   wipa_core_if.erx        cif,
   input  wire logic       rx_pkt_start,
   input  wire logic [3:0] rx_dma_bytes
);
   import wipa_pkg::*;

   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        armed_q;
   logic        fire;
   logic        irq_q;

   assign count_d = count_q + {12'h000, rx_dma_bytes};
   // A zero threshold never fires early; the packet end interrupt covers it.
   // The multiple enable makes every packet eligible, whatever the single-shot state.
   assign fire = cif.erx_mode && (armed_q || cif.erx_multi) && (cif.erx_thr != THR_RST)
                 && (count_q < {4'h0, cif.erx_thr}) && (count_d >= {4'h0, cif.erx_thr});

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         count_q <= 16'h0000;
      else if (rx_pkt_start)
         count_q <= 16'h0000;
      else
         count_q <= count_d;
   end

   // Without the multiple enable only one packet fires until software rearms.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         armed_q <= 1'b1;
      else if (cif.erx_rearm)
         armed_q <= 1'b1;
      else if (fire && !cif.erx_multi)
         armed_q <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= fire;
   end

   assign cif.erx_irq = irq_q;
endmodule : wipa_erx_eng

// file: wipa_mdio_eng.sv
// Serial management engine: one clause 22 frame per start request.
// Assumes start arrives only while idle; the PHY answers on mdio_i.
`timescale 1ns/100ps
module wipa_mdio_eng (
   input  wire logic clk,
   input  wire logic rst,
   wipa_core_if.mdio cif,
   output logic      mdc,
   output logic      mdio_o,
   output logic      mdio_oe,
   input  wire logic mdio_i
);
   import wipa_pkg::*;

   wipa_md_state_t          state_q;
   logic [1:0]              div_q;
   logic                    mdc_q;
   logic [FRAME_BITS-1:0]   frame_q;
   logic [6:0]              bit_q;
   logic                    wr_q;
   logic [DATA_W-1:0]       rdata_q;
   logic                    done_q;
   logic                    tick;

   assign tick = (state_q == WIPA_MD_RUN) && (div_q == 2'(MDC_HALF_CYC - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= WIPA_MD_IDLE;
         div_q   <= 2'h0;
         mdc_q   <= 1'b0;
         frame_q <= '0;
         bit_q   <= 7'h00;
         wr_q    <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            WIPA_MD_IDLE: begin
               if (cif.md_start) begin
                  // Fixed PHY address and programmed index go into every frame.
                  frame_q <= {PREAMBLE, FRM_ST, cif.md_write ? OP_WR : OP_RD, PHY_ADDR, cif.md_reg,
                              TA_WR, cif.md_wdata};
                  wr_q    <= cif.md_write;
                  bit_q   <= 7'h00;
                  div_q   <= 2'h0;
                  mdc_q   <= 1'b0;
                  state_q <= WIPA_MD_RUN;
               end
            end
            WIPA_MD_RUN: begin
               div_q <= tick ? 2'h0 : div_q + 2'h1;
               if (tick) begin
                  mdc_q <= ~mdc_q;
                  if (mdc_q) begin
                     if (bit_q == 7'(FRAME_BITS - 1)) begin
                        state_q <= WIPA_MD_IDLE;
                        done_q  <= 1'b1;
                     end else begin
                        bit_q   <= bit_q + 7'h01;
                        frame_q <= {frame_q[FRAME_BITS-2:0], 1'b0};
                     end
                  end
               end
            end
            default: state_q <= WIPA_MD_IDLE;
         endcase
      end
   end

   // Read data is sampled on the rising management clock edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdata_q <= '0;
      else if (tick && !mdc_q && !wr_q && bit_q >= 7'(DATA_BIT))
         rdata_q <= {rdata_q[DATA_W-2:0], mdio_i};
   end

   assign mdc          = mdc_q;
   assign mdio_o       = frame_q[FRAME_BITS-1];
   assign mdio_oe      = (state_q == WIPA_MD_RUN) && (wr_q || bit_q < 7'(TA_BIT));
   assign cif.md_done  = done_q;
   assign cif.md_rdata = rdata_q;
endmodule : wipa_mdio_eng

// file: wipa_phy_model.sv
// Behavioural PHY management register file answering clause 22 frames.
// Assumes it sees the resolved data line, which idles high through a pull-up.
`timescale 1ns/100ps
module wipa_phy_model (
   input  wire logic mdc,
   input  wire logic md_line,
   output logic      md_drv
);
   import wipa_pkg::*;
   logic [15:0] mem [32];
   logic [15:0] hdr;
   logic [4:0]  idx;
   logic        rd_q;
   logic        wr_q;
   int          ones;
   int          pos;

   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 16'h5a00 | 16'(i);
      ones = 0;
      pos = 0;
      md_drv = 1'b1;
   end

   // Only frames for the fixed address are answered; others see the pull-up.
   always @(posedge mdc) begin
      if (pos == 0) begin
         ones <= md_line ? ones + 1 : 0;
         if (!md_line && ones >= 32) pos <= 1;
      end else begin
         hdr <= {hdr[14:0], md_line};
         pos <= pos + 1;
         if (pos == 14) begin
            rd_q <= hdr[11:10] == OP_RD && hdr[9:5] == PHY_ADDR;
            wr_q <= hdr[11:10] == OP_WR && hdr[9:5] == PHY_ADDR;
            idx <= hdr[4:0];
            if (hdr[11:10] == OP_RD && hdr[9:5] == PHY_ADDR) md_drv <= 1'b0;
         end
         if (pos >= 15 && pos <= 30 && rd_q) md_drv <= mem[idx][30-pos];
         if (pos == 31) begin
            if (wr_q) mem[idx] <= {hdr[14:0], md_line};
            md_drv <= 1'b1;
            ones <= 0;
            pos <= 0;
         end
      end
   end
endmodule : wipa_phy_model

// file: wipa_pkg.sv
// Constants for the wake, early receive and PHY access register slice.
// Assumes byte addresses on the register port, one 32-bit word per register.
package wipa_pkg;
   // Register indexes; the byte address is four times the index.
   localparam logic [7:0] IDX_WAKE_CFG  = 8'h56;
   localparam logic [7:0] IDX_ERX_THR   = 8'h5c;
   localparam logic [7:0] IDX_PHY_ACC   = 8'h60;
   localparam logic [7:0] IDX_WAKE_CTRL = 8'h70;
   localparam int         ADDR_W        = 10;

   // Wake configuration fields.
   localparam int BIT_BCAST_WF   = 6;
   localparam int BIT_MCAST_WF   = 5;
   localparam int BIT_UCAST_WF   = 4;
   localparam int BIT_WAKE_PIN   = 1;
   localparam int BIT_PES_SEL    = 0;
   localparam logic [7:0] WAKE_CFG_RST  = 8'h00;
   localparam logic [7:0] WAKE_CFG_MASK = 8'h73;

   // Wake control and status fields.
   localparam int BIT_GATE_SEL   = 0;
   localparam int BIT_PES        = 1;
   localparam int BIT_MULTI_ERX  = 2;
   localparam int BIT_EARLY_MODE = 3;
   localparam int BIT_ERX_FLAG   = 4;

   // Early receive threshold.
   localparam int THR_W = 12;
   localparam logic [THR_W-1:0] THR_RST = 12'h000;

   // PHY access fields.
   localparam int BIT_ACC_FLAG = 31;
   localparam int REG_LO       = 16;
   localparam int REG_W        = 5;
   localparam int DATA_W       = 16;

   // Management frame layout, bits numbered from the first sent.
   localparam int          FRAME_BITS = 64;
   localparam int          TA_BIT     = 46;
   localparam int          DATA_BIT   = 48;
   localparam logic [31:0] PREAMBLE   = 32'hFFFF_FFFF;
   localparam logic [1:0]  FRM_ST     = 2'h1;
   localparam logic [1:0]  OP_WR      = 2'h1;
   localparam logic [1:0]  OP_RD      = 2'h2;
   localparam logic [1:0]  TA_WR      = 2'h2;
   localparam logic [4:0]  PHY_ADDR   = 5'h01;

   // Management clock timing.
   localparam int CLK_PERIOD_NS     = 100;
   localparam int MDC_MIN_PERIOD_NS = 400;
   localparam int MDC_HALF_CYC      = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      WIPA_MD_IDLE = 2'b01,
      WIPA_MD_RUN  = 2'b10
   } wipa_md_state_t;
endpackage : wipa_pkg

// file: wipa_reg_bank.sv
// Register bank for wake configuration, early receive threshold and PHY access.
// Assumes a single-cycle strobe master on the register port, synchronous inputs.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module wipa_reg_bank (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [wipa_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_we,
   input  wire logic                         reg_re,
   output logic      [31:0]                  reg_rdata,
   input  wire logic                         host_bus_reset,
   input  wire logic                         eeprom_load,
   input  wire logic [1:0]                   eeprom_wake_bits,
   input  wire logic                         wake_frame_hit,
   input  wire logic                         wake_frame_bcast,
   input  wire logic                         wake_frame_mcast,
   input  wire logic                         wake_frame_ucast,
   input  wire logic                         power_event_req,
   input  wire logic                         isolation_in_n,
   output logic                              power_event_out_n,
   output logic                              lan_wake_pin,
   input  wire logic                         rx_pkt_start,
   input  wire logic [3:0]                   rx_dma_bytes,
   output logic                              early_rx_irq,
   output logic                              mdc,
   output logic                              mdio_o,
   output logic                              mdio_oe,
   input  wire logic                         mdio_i
);
   import wipa_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   wipa_core_if cif ();

   logic [7:0]        wake_cfg_q;
   logic [THR_W-1:0]  erx_thr_q;
   logic              acc_flag_q;
   logic [REG_W-1:0]  phy_reg_index_q;
   logic [DATA_W-1:0] phy_reg_value_q;
   logic              busy_q;
   logic              start_q;
   logic              wake_pin_gating_sel_q;
   logic              pes_q;
   logic              multi_q;
   logic              early_mode_q;
   logic              erx_flag_q;
   logic [31:0]       rdata_q;
   logic              wake_event;
   logic              pes_clr;
   logic              bcast_wake_frame_en;
   logic              mcast_wake_frame_en;
   logic              ucast_wake_frame_en;
   logic              wake_pin_en;
   logic              power_event_status_clear_sel;

   assign bcast_wake_frame_en          = wake_cfg_q[BIT_BCAST_WF];
   assign mcast_wake_frame_en          = wake_cfg_q[BIT_MCAST_WF];
   assign ucast_wake_frame_en          = wake_cfg_q[BIT_UCAST_WF];
   assign wake_pin_en                  = wake_cfg_q[BIT_WAKE_PIN];
   assign power_event_status_clear_sel = wake_cfg_q[BIT_PES_SEL];

   // Wake configuration: writable at any time, reserved bits hold zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_cfg_q <= WAKE_CFG_RST;
      end else begin
         if (reg_we && hit(reg_addr, IDX_WAKE_CFG))
            wake_cfg_q <= reg_wdata[7:0] & WAKE_CFG_MASK;
         if (eeprom_load) begin
            wake_cfg_q[BIT_WAKE_PIN] <= eeprom_wake_bits[BIT_WAKE_PIN];
            wake_cfg_q[BIT_PES_SEL]  <= eeprom_wake_bits[BIT_PES_SEL];
         end
      end
   end

   // A wake frame counts only when its kind is enabled.
   assign wake_event = wake_frame_hit && ((wake_frame_bcast && bcast_wake_frame_en)
                                          || (wake_frame_mcast && mcast_wake_frame_en)
                                          || (wake_frame_ucast && ucast_wake_frame_en));

   assign pes_clr = (reg_we && hit(reg_addr, IDX_WAKE_CTRL) && reg_wdata[BIT_PES])
                    || (host_bus_reset && power_event_status_clear_sel);

   // Power event status; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pes_q <= 1'b0;
      else if (wake_event || power_event_req)
         pes_q <= 1'b1;
      else if (pes_clr)
         pes_q <= 1'b0;
   end

   // Control bits of the wake and early receive logic.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_pin_gating_sel_q <= 1'b0;
         multi_q               <= 1'b0;
         early_mode_q          <= 1'b0;
      end else if (reg_we && hit(reg_addr, IDX_WAKE_CTRL)) begin
         wake_pin_gating_sel_q <= reg_wdata[BIT_GATE_SEL];
         multi_q               <= reg_wdata[BIT_MULTI_ERX];
         early_mode_q          <= reg_wdata[BIT_EARLY_MODE];
      end
   end

   assign power_event_out_n = ~pes_q;
   assign lan_wake_pin      = wake_pin_en
                              && pes_q && (!wake_pin_gating_sel_q || !isolation_in_n);

   // Early receive threshold; writing it also rearms a single-shot interrupt.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         erx_thr_q <= THR_RST;
      else if (reg_we && hit(reg_addr, IDX_ERX_THR))
         erx_thr_q <= reg_wdata[THR_W-1:0];
   end

   assign cif.erx_thr   = erx_thr_q;
   assign cif.erx_multi = multi_q;
   assign cif.erx_mode  = early_mode_q;
   assign cif.erx_rearm = reg_we && hit(reg_addr, IDX_ERX_THR);
   assign early_rx_irq  = cif.erx_irq;

   // Sticky view of the early receive pulse; the event wins over a clear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         erx_flag_q <= 1'b0;
      else if (cif.erx_irq)
         erx_flag_q <= 1'b1;
      else if (reg_we && hit(reg_addr, IDX_WAKE_CTRL) && reg_wdata[BIT_ERX_FLAG])
         erx_flag_q <= 1'b0;
   end

   wipa_erx_eng u_erx (
      .clk          (clk),
      .rst          (rst),
      .cif          (cif.erx),
      .rx_pkt_start (rx_pkt_start),
      .rx_dma_bytes (rx_dma_bytes)
   );

   // PHY access register. Writes while an access runs are ignored.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_flag_q      <= 1'b0;
         phy_reg_index_q <= '0;
         phy_reg_value_q <= '0;
         busy_q          <= 1'b0;
         start_q         <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (reg_we && hit(reg_addr, IDX_PHY_ACC) && !busy_q) begin
            acc_flag_q      <= reg_wdata[BIT_ACC_FLAG];
            phy_reg_index_q <= reg_wdata[REG_LO +: REG_W];
            phy_reg_value_q <= reg_wdata[DATA_W-1:0];
            busy_q          <= 1'b1;
            start_q         <= 1'b1;
         end else if (cif.md_done) begin
            busy_q     <= 1'b0;
            acc_flag_q <= ~acc_flag_q;
            if (!acc_flag_q)
               phy_reg_value_q <= cif.md_rdata;
         end
      end
   end

   assign cif.md_start = start_q;
   assign cif.md_write = acc_flag_q;
   assign cif.md_reg   = phy_reg_index_q;
   assign cif.md_wdata = phy_reg_value_q;

   wipa_mdio_eng u_mdio (
      .clk     (clk),
      .rst     (rst),
      .cif     (cif.mdio),
      .mdc     (mdc),
      .mdio_o  (mdio_o),
      .mdio_oe (mdio_oe),
      .mdio_i  (mdio_i)
   );

   // Read data stand for one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_re) begin
            if (hit(reg_addr, IDX_WAKE_CFG))
               rdata_q <= {24'h00_0000, wake_cfg_q};
            else if (hit(reg_addr, IDX_ERX_THR))
               rdata_q <= {20'h0_0000, erx_thr_q};
            else if (hit(reg_addr, IDX_PHY_ACC))
               rdata_q <= {acc_flag_q, 10'h000, phy_reg_index_q, phy_reg_value_q};
            else if (hit(reg_addr, IDX_WAKE_CTRL))
               rdata_q <= {27'h000_0000, erx_flag_q, early_mode_q, multi_q, pes_q, wake_pin_gating_sel_q};
         end
      end
   end

   assign reg_rdata = rdata_q;
endmodule : wipa_reg_bank

// file: wipa_sva.sv
// Checker for the wake, early receive and PHY access register slice.
// Assumes it is bound to wipa_reg_bank and sees only its ports.
`timescale 1ns/100ps
module wipa_sva (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        reg_we,
   input wire logic        reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic        host_bus_reset,
   input wire logic        power_event_req,
   input wire logic        power_event_out_n,
   input wire logic        lan_wake_pin,
   input wire logic        early_rx_irq,
   input wire logic        mdc,
   input wire logic        mdio_o,
   input wire logic        mdio_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_rdata_idle_zero: assert property (!reg_re |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read");
   a_wake_needs_event: assert property (lan_wake_pin |-> !power_event_out_n)
      else $error("wake pin without power event");
   a_event_sets_status: assert property (power_event_req |=> !power_event_out_n)
      else $error("power event not latched");
   a_status_sticky: assert property ($rose(power_event_out_n) |-> $past(reg_we) || $past(host_bus_reset))
      else $error("power event status lost without clear");
   a_irq_one_pulse: assert property (early_rx_irq |=> !early_rx_irq)
      else $error("early receive irq longer than one cycle");
   a_mdc_half_period: assert property ($rose(mdc) |=> mdc ##1 !mdc)
      else $error("management clock high time wrong");
   a_mdio_at_fall: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_o) |-> $fell(mdc))
      else $error("management data changed off the clock fall");
   a_preamble_ones: assert property ($rose(mdio_oe) |=> (mdio_oe && mdio_o) [*8])
      else $error("frame does not open with ones");

   c_early_irq: cover property (early_rx_irq);
   c_frame_end: cover property ($fell(mdio_oe));
   c_wake_pin: cover property (lan_wake_pin);
endmodule : wipa_sva

bind wipa_reg_bank wipa_sva u_wipa_sva (
   .clk(clk), .rst(rst), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
   .host_bus_reset(host_bus_reset), .power_event_req(power_event_req),
   .power_event_out_n(power_event_out_n), .lan_wake_pin(lan_wake_pin), .early_rx_irq(early_rx_irq),
   .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe)
);
